// *** rtl/lbc_regs.svh ***
// register offsets, field positions, reset values and timing counts
`ifndef LBC_REGS_SVH
`define LBC_REGS_SVH
`define LBC_CLK_KHZ 10000
`define LBC_CLK_NS 100
`define LBC_OFF_BOOST 8'h00
`define LBC_OFF_SINK 8'h04
`define LBC_OFF_PWM 8'h08
`define LBC_OFF_FS_A 8'h0C
`define LBC_OFF_BR_A 8'h10
`define LBC_OFF_FS_B 8'h14
`define LBC_OFF_BR_B 8'h18
`define LBC_OFF_STATUS 8'h1C
`define LBC_BOOST_FREQ_BIT 0
`define LBC_PWM_EN_A_BIT 0
`define LBC_PWM_EN_B_BIT 1
`define LBC_PWM_POL_BIT 2
`define LBC_PWM_ZD_OFF_BIT 3
`define LBC_ST_EN_BIT 0
`define LBC_ST_HOT_BIT 1
`define LBC_ST_ACTIVE_BIT 2
`define LBC_ST_DUTY_LSB 8
`define LBC_BOOST_RST 1'h0
`define LBC_SINK_RST 3'h0
`define LBC_PWM_RST 4'h0
`define LBC_FS_RST 5'h13
`define LBC_BR_RST 11'h000
`define LBC_SLOW_KHZ 500
`define LBC_FAST_KHZ 1000
`define LBC_SLOW_HALF ((`LBC_CLK_KHZ / `LBC_SLOW_KHZ) / 2)
`define LBC_FAST_HALF ((`LBC_CLK_KHZ / `LBC_FAST_KHZ) / 2)
`define LBC_MIN_PULSE_NS 750
`define LBC_MIN_PULSE_CYC ((`LBC_MIN_PULSE_NS + `LBC_CLK_NS - 1) / `LBC_CLK_NS)
`define LBC_WINDOW_CYC 8192
`define LBC_DUTY_ONE 9'h100
`define LBC_RESP_OKAY 2'h0
`define LBC_RESP_SLVERR 2'h2
`endif

// *** rtl/lbc_pkg.sv ***
// shared types of the led bank control block
package lbc_pkg;
	typedef enum logic {LBC_BANK_A = 1'h0, LBC_BANK_B = 1'h1} lbc_bank_type;
	typedef logic [4:0] lbc_fs_type;
	typedef logic [10:0] lbc_bright_type;
	typedef logic [8:0] lbc_duty_type;
endpackage : lbc_pkg

// *** rtl/lbc_sync.sv ***
// three-stage synchroniser with agreement filter for pin levels
`timescale 1ns/1ps
module lbc_sync #(
	parameter int WIDTH = 1
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] s1_reg; // metastable stage, read by s2 only
	logic [WIDTH-1:0] s2_reg;
	logic [WIDTH-1:0] s3_reg;
	logic [WIDTH-1:0] out_reg; // filtered level
	logic [WIDTH-1:0] out_next;

	// a change counts only once stages two and three agree
	always_comb begin
		out_next = out_reg;
		for (int i = 0; i < WIDTH; i++) begin
			if (s2_reg[i] == s3_reg[i]) begin
				out_next[i] = s3_reg[i];
			end
		end
	end

	// shift chain
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s1_reg <= '0;
			s2_reg <= '0;
			s3_reg <= '0;
			out_reg <= '0;
		end else begin
			s1_reg <= async_in;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			out_reg <= out_next;
		end
	end

	assign sync_out = out_reg;
endmodule : lbc_sync

// *** rtl/lbc_duty_meter.sv ***
// duty-cycle meter for the pwm input with near-zero pulse rejection
`timescale 1ns/1ps
`include "lbc_regs.svh"
module lbc_duty_meter
	import lbc_pkg::*;
#(
	parameter int WINDOW_CYC = `LBC_WINDOW_CYC,
	parameter int MIN_PULSE = `LBC_MIN_PULSE_CYC
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic clear,
	input wire logic pwm_level,
	input wire logic active_low,
	input wire logic zd_disable,
	output lbc_duty_type duty_out
);
	localparam int CW = $clog2(WINDOW_CYC) + 1;
	localparam int RW = $clog2(MIN_PULSE + 1);
	localparam int SHIFT = $clog2(WINDOW_CYC) - 8;

	logic [CW-1:0] win_reg; // position in window
	logic [CW-1:0] win_next;
	logic [CW-1:0] high_reg; // credited high samples
	logic [CW-1:0] high_next;
	logic [CW-1:0] credit;
	logic [CW-1:0] total;
	logic [RW-1:0] run_reg; // length of current pulse, saturating
	logic [RW-1:0] run_next;
	lbc_duty_type duty_reg; // 0x100 means full duty
	lbc_duty_type duty_next;
	logic level;

	// fixed window acts as the low-pass; ripple is the trade-off
	always_comb begin
		level = pwm_level ^ active_low;
		credit = '0;
		run_next = '0;
		if (level) begin
			run_next = (run_reg == RW'(MIN_PULSE)) ? run_reg : run_reg + 1'h1;
			// short pulses earn nothing until they reach the minimum
			if (zd_disable || run_reg >= RW'(MIN_PULSE)) begin
				credit = CW'(1);
			end else if (run_reg == RW'(MIN_PULSE - 1)) begin
				credit = CW'(MIN_PULSE);
			end
		end
		total = high_reg + credit;
		win_next = win_reg + 1'h1;
		high_next = total;
		duty_next = duty_reg;
		// window end: publish the fraction scaled to 256
		if (win_reg == CW'(WINDOW_CYC - 1)) begin
			win_next = '0;
			high_next = '0;
			duty_next = lbc_duty_type'(total >> SHIFT);
		end
	end

	// state registers; clear follows the enable pin
	always_ff @(posedge aclk) begin
		if (!aresetn || clear) begin
			win_reg <= '0;
			high_reg <= '0;
			run_reg <= '0;
			duty_reg <= '0;
		end else begin
			win_reg <= win_next;
			high_reg <= high_next;
			run_reg <= run_next;
			duty_reg <= duty_next;
		end
	end

	assign duty_out = duty_reg;
endmodule : lbc_duty_meter

// *** rtl/lbc_top.sv ***
// led bank control top: register slave, bank mapping, boost clock
`timescale 1ns/1ps
`include "lbc_regs.svh"

// Notes on behaviour
// - duty input may steer bank a or b
// - assigned bank level scales with measured duty
// - enable low: shutdown, registers to defaults
// - thermal trip stops boost, sinks until cool
// - banks hold 5-bit scale, 11-bit brightness
// - sink config maps each string to bank
// - boost clock runs 500 khz or 1 mhz
// - pwm config bit 3 disables zero detect
// - boost control bit 0 picks the rate
module lbc_top
	import lbc_pkg::*;
#(
	parameter int WINDOW_CYC = `LBC_WINDOW_CYC
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic global_enable_pin,
	input wire logic pwm_pin,
	input wire logic temp_hot_pin,
	input wire logic temp_cool_pin,
	output logic boost_enable,
	output logic boost_clk,
	output logic [2:0] sink_enable,
	output logic [2:0][4:0] sink_fullscale,
	output logic [2:0][10:0] sink_level
);
	////////////////////////////////////////////////////////////////////////
	// helpers

	// merge write data into an old value by byte lane
	function automatic logic [31:0] lbc_merge(input logic [31:0] old_val,
		input logic [31:0] new_val, input logic [3:0] strb);
		logic [31:0] res;
		res = old_val;
		for (int k = 0; k < 4; k++) begin
			if (strb[k]) begin
				res[8*k +: 8] = new_val[8*k +: 8];
			end
		end
		return res;
	endfunction : lbc_merge

	// true for any of the eight word addresses
	function automatic logic lbc_mapped(input logic [7:0] addr);
		return (addr[1:0] == 2'h0) && (addr <= `LBC_OFF_STATUS);
	endfunction : lbc_mapped

	////////////////////////////////////////////////////////////////////////
	// pin synchronisers

	logic [3:0] pins_sync; // enable, pwm, hot, cool
	logic en_sync;
	logic pwm_sync;
	logic hot_sync;
	logic cool_sync;

	// every pin is asynchronous to aclk
	lbc_sync #(.WIDTH(4)) u_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.async_in({temp_cool_pin, temp_hot_pin, pwm_pin, global_enable_pin}),
		.sync_out(pins_sync)
	);
	assign en_sync = pins_sync[0];
	assign pwm_sync = pins_sync[1];
	assign hot_sync = pins_sync[2];
	assign cool_sync = pins_sync[3];

	////////////////////////////////////////////////////////////////////////
	// write and read channels

	logic aw_full_reg, aw_full_next; // write address held
	logic [7:0] aw_addr_reg, aw_addr_next;
	logic w_full_reg, w_full_next; // write data held
	logic [31:0] w_data_reg, w_data_next;
	logic [3:0] w_strb_reg, w_strb_next;
	logic bvalid_reg, bvalid_next;
	logic [1:0] bresp_reg, bresp_next;
	logic rvalid_reg, rvalid_next;
	logic [1:0] rresp_reg, rresp_next;
	logic [31:0] rdata_reg, rdata_next;
	logic do_write; // both halves present
	logic [31:0] status_word;
	logic boost_reg, boost_next; // 1 selects the fast rate
	logic [2:0] sink_reg, sink_next; // bank per string, 1 = bank b
	logic [3:0] pwm_reg, pwm_next; // enables, polarity, zero detect off
	lbc_fs_type fs_reg [2]; // full-scale per bank
	lbc_fs_type fs_next [2];
	lbc_bright_type br_reg [2]; // brightness per bank
	lbc_bright_type br_next [2];

	// one write in flight: stall both channels until b is taken
	assign s_axi_awready = !aw_full_reg && !bvalid_reg;
	assign s_axi_wready = !w_full_reg && !bvalid_reg;
	assign s_axi_arready = !rvalid_reg;
	assign do_write = aw_full_reg && w_full_reg;

	// channel next-state
	always_comb begin
		aw_full_next = aw_full_reg;
		aw_addr_next = aw_addr_reg;
		w_full_next = w_full_reg;
		w_data_next = w_data_reg;
		w_strb_next = w_strb_reg;
		bvalid_next = bvalid_reg;
		bresp_next = bresp_reg;
		rvalid_next = rvalid_reg;
		rresp_next = rresp_reg;
		rdata_next = rdata_reg;
		// address and data may come in either order
		if (s_axi_awvalid && s_axi_awready) begin
			aw_full_next = 1'h1;
			aw_addr_next = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			w_full_next = 1'h1;
			w_data_next = s_axi_wdata;
			w_strb_next = s_axi_wstrb;
		end
		// commit and answer
		if (do_write) begin
			aw_full_next = 1'h0;
			w_full_next = 1'h0;
			bvalid_next = 1'h1;
			bresp_next = lbc_mapped(aw_addr_reg) ? `LBC_RESP_OKAY :
				`LBC_RESP_SLVERR;
		end else if (bvalid_reg && s_axi_bready) begin
			bvalid_next = 1'h0;
		end
		// read: data is ready one cycle after the address
		if (s_axi_arvalid && s_axi_arready) begin
			rvalid_next = 1'h1;
			rresp_next = `LBC_RESP_OKAY;
			rdata_next = 32'h0000_0000;
			unique case (s_axi_araddr)
				`LBC_OFF_BOOST: rdata_next = 32'(boost_reg);
				`LBC_OFF_SINK: rdata_next = 32'(sink_reg);
				`LBC_OFF_PWM: rdata_next = 32'(pwm_reg);
				`LBC_OFF_FS_A: rdata_next = 32'(fs_reg[0]);
				`LBC_OFF_BR_A: rdata_next = 32'(br_reg[0]);
				`LBC_OFF_FS_B: rdata_next = 32'(fs_reg[1]);
				`LBC_OFF_BR_B: rdata_next = 32'(br_reg[1]);
				`LBC_OFF_STATUS: rdata_next = status_word;
				default: rresp_next = `LBC_RESP_SLVERR; // unmapped
			endcase
		end else if (rvalid_reg && s_axi_rready) begin
			rvalid_next = 1'h0;
		end
	end

	// channel registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_full_reg <= 1'h0;
			aw_addr_reg <= 8'h00;
			w_full_reg <= 1'h0;
			w_data_reg <= 32'h0000_0000;
			w_strb_reg <= 4'h0;
			bvalid_reg <= 1'h0;
			bresp_reg <= `LBC_RESP_OKAY;
			rvalid_reg <= 1'h0;
			rresp_reg <= `LBC_RESP_OKAY;
			rdata_reg <= 32'h0000_0000;
		end else begin
			aw_full_reg <= aw_full_next;
			aw_addr_reg <= aw_addr_next;
			w_full_reg <= w_full_next;
			w_data_reg <= w_data_next;
			w_strb_reg <= w_strb_next;
			bvalid_reg <= bvalid_next;
			bresp_reg <= bresp_next;
			rvalid_reg <= rvalid_next;
			rresp_reg <= rresp_next;
			rdata_reg <= rdata_next;
		end
	end

	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp = bresp_reg;
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rresp = rresp_reg;
	assign s_axi_rdata = rdata_reg;

	////////////////////////////////////////////////////////////////////////
	// configuration registers, declared with the channels for the read mux

	// software writes; enable low forces defaults and drops writes
	always_comb begin
		boost_next = boost_reg;
		sink_next = sink_reg;
		pwm_next = pwm_reg;
		fs_next = fs_reg;
		br_next = br_reg;
		if (!en_sync) begin
			boost_next = `LBC_BOOST_RST;
			sink_next = `LBC_SINK_RST;
			pwm_next = `LBC_PWM_RST;
			fs_next = '{`LBC_FS_RST, `LBC_FS_RST};
			br_next = '{`LBC_BR_RST, `LBC_BR_RST};
		end else if (do_write) begin
			unique case (aw_addr_reg)
				`LBC_OFF_BOOST: boost_next = 1'(lbc_merge(32'(boost_reg),
					w_data_reg, w_strb_reg));
				`LBC_OFF_SINK: sink_next = 3'(lbc_merge(32'(sink_reg),
					w_data_reg, w_strb_reg));
				`LBC_OFF_PWM: pwm_next = 4'(lbc_merge(32'(pwm_reg),
					w_data_reg, w_strb_reg));
				`LBC_OFF_FS_A: fs_next[0] = 5'(lbc_merge(32'(fs_reg[0]),
					w_data_reg, w_strb_reg));
				`LBC_OFF_BR_A: br_next[0] = 11'(lbc_merge(32'(br_reg[0]),
					w_data_reg, w_strb_reg));
				`LBC_OFF_FS_B: fs_next[1] = 5'(lbc_merge(32'(fs_reg[1]),
					w_data_reg, w_strb_reg));
				`LBC_OFF_BR_B: br_next[1] = 11'(lbc_merge(32'(br_reg[1]),
					w_data_reg, w_strb_reg));
				default: ; // status and unmapped: no storage
			endcase
		end
	end

	// configuration flops
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			boost_reg <= `LBC_BOOST_RST;
			sink_reg <= `LBC_SINK_RST;
			pwm_reg <= `LBC_PWM_RST;
			fs_reg <= '{`LBC_FS_RST, `LBC_FS_RST};
			br_reg <= '{`LBC_BR_RST, `LBC_BR_RST};
		end else begin
			boost_reg <= boost_next;
			sink_reg <= sink_next;
			pwm_reg <= pwm_next;
			fs_reg <= fs_next;
			br_reg <= br_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// duty measurement, thermal latch and bank scaling

	lbc_duty_type duty_meas; // 0x100 = full duty
	lbc_duty_type bank_duty [2];
	lbc_bright_type bank_scaled [2];
	logic hot_reg, hot_next; // thermal shutdown latched
	logic active_reg, active_next; // boost and sinks allowed

	lbc_duty_meter #(.WINDOW_CYC(WINDOW_CYC)) u_duty (
		.aclk(aclk),
		.aresetn(aresetn),
		.clear(!en_sync),
		.pwm_level(pwm_sync),
		.active_low(pwm_reg[`LBC_PWM_POL_BIT]),
		.zd_disable(pwm_reg[`LBC_PWM_ZD_OFF_BIT]),
		.duty_out(duty_meas)
	);

	// level per bank: brightness times duty, or brightness alone
	for (genvar b = 0; b < 2; b++) begin : g_bank
		logic [19:0] prod;
		assign bank_duty[b] = pwm_reg[b] ? duty_meas : `LBC_DUTY_ONE;
		assign prod = br_reg[b] * bank_duty[b];
		assign bank_scaled[b] = prod[18:8];
	end

	// hysteresis: trip sets, cool clears, a trip wins over a clear
	always_comb begin
		hot_next = hot_reg;
		if (hot_sync) begin
			hot_next = 1'h1;
		end else if (cool_sync) begin
			hot_next = 1'h0;
		end
		active_next = en_sync && !hot_reg;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			hot_reg <= 1'h0;
			active_reg <= 1'h0;
		end else begin
			hot_reg <= hot_next;
			active_reg <= active_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// string sinks and boost clock

	logic [2:0][4:0] sfs_reg, sfs_next;
	logic [2:0][10:0] slv_reg, slv_next;
	logic [3:0] div_reg, div_next; // half-period counter
	logic clk_reg, clk_next;
	logic [3:0] half_cyc;

	// each string follows the bank chosen for it; zero when off
	always_comb begin
		for (int s = 0; s < 3; s++) begin
			sfs_next[s] = active_next ? fs_reg[sink_reg[s]] : 5'h00;
			slv_next[s] = active_next ? bank_scaled[sink_reg[s]] : 11'h000;
		end
	end

	// divider restarts when disabled; a rate change takes effect at once
	always_comb begin
		half_cyc = boost_reg ? 4'(`LBC_FAST_HALF) : 4'(`LBC_SLOW_HALF);
		div_next = div_reg + 4'h1;
		clk_next = clk_reg;
		// stop in step with the enable flop, so no stray edge when off
		if (!active_next) begin
			div_next = 4'h0;
			clk_next = 1'h0;
		end else if (div_reg >= half_cyc - 4'h1) begin
			div_next = 4'h0;
			clk_next = !clk_reg;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sfs_reg <= '0;
			slv_reg <= '0;
			div_reg <= 4'h0;
			clk_reg <= 1'h0;
		end else begin
			sfs_reg <= sfs_next;
			slv_reg <= slv_next;
			div_reg <= div_next;
			clk_reg <= clk_next;
		end
	end

	assign boost_enable = active_reg;
	assign boost_clk = clk_reg;
	assign sink_enable = {3{active_reg}};
	assign sink_fullscale = sfs_reg;
	assign sink_level = slv_reg;
	assign status_word = {15'h0000, duty_meas, 5'h00, active_reg, hot_reg,
		en_sync};

	////////////////////////////////////////////////////////////////////////
	// assertions

	lbc_fs_type fs_src0; // bank full-scale feeding string 1
	lbc_bright_type br_a;
	assign fs_src0 = fs_reg[sink_reg[0]];
	assign br_a = br_reg[0];

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence s_write_both;
		aw_full_reg && w_full_reg;
	endsequence
	sequence s_read_bad;
		s_axi_arvalid && s_axi_arready && !lbc_mapped(s_axi_araddr);
	endsequence

	a_write_answer: assert property (s_write_both |=> s_axi_bvalid
		&& !s_axi_awready && !s_axi_wready)
		else $error("write not answered in one cycle");
	a_read_unmapped: assert property (s_read_bad |=> s_axi_rvalid
		&& s_axi_rresp == `LBC_RESP_SLVERR)
		else $error("unmapped read not refused");
	a_shutdown_outs: assert property (!en_sync |=> !boost_enable
		&& sink_enable == 3'h0 && !boost_clk)
		else $error("outputs alive while enable low");
	a_config_default: assert property (!en_sync |=> pwm_reg == `LBC_PWM_RST
		&& sink_reg == `LBC_SINK_RST && boost_reg == `LBC_BOOST_RST)
		else $error("registers not defaulted while enable low");
	a_thermal_hold: assert property (hot_reg && !cool_sync |=> hot_reg
		##1 !boost_enable)
		else $error("thermal shutdown released early");
	a_sink_map: assert property (active_next |=>
		sink_fullscale[0] == $past(fs_src0))
		else $error("string 1 not on its bank");
	a_duty_one: assert property (!pwm_reg[0] && sink_reg[0] == 1'h0
		&& active_next |=> sink_level[0] == $past(br_a))
		else $error("pwm off must give plain brightness");
	a_duty_zero: assert property (pwm_reg[0] && duty_meas == 9'h000
		&& sink_reg[0] == 1'h0 |=> sink_level[0] == 11'h000)
		else $error("zero duty must give zero level");
	a_slow_half: assert property ($rose(boost_clk) && !boost_reg &&
		active_reg ##1 (!boost_reg && active_reg)[*8] |-> boost_clk)
		else $error("slow boost half period too short");
	a_fast_half: assert property ($rose(boost_clk) && boost_reg &&
		active_reg ##1 (boost_reg && active_reg)[*5] |-> !boost_clk)
		else $error("fast boost half period wrong");
endmodule : lbc_top

// *** test/lbc_pwm_source.sv ***
// pwm brightness source standing in for the host's pwm output
`timescale 1ns/1ps
module lbc_pwm_source (
	input wire logic aclk,
	input wire logic [7:0] high_cyc,
	input wire logic [7:0] low_cyc,
	output logic pwm_pin
);
	// position inside one pwm period
	logic [8:0] pos_reg = 9'h000;
	// period length, never zero in use
	logic [8:0] period;
	assign period = {1'b0, high_cyc} + {1'b0, low_cyc};
	// high part first, then low; short pulses only when a test asks
	always_ff @(posedge aclk) begin
		if (pos_reg + 9'h001 >= period) begin
			pos_reg <= 9'h000;
		end else begin
			pos_reg <= pos_reg + 9'h001;
		end
		pwm_pin <= (pos_reg < {1'b0, high_cyc});
	end
endmodule : lbc_pwm_source

// *** test/led_bank_control_bench.sv ***
// self-checking bench for the led bank control block
`timescale 1ns/1ps
`include "lbc_regs.svh"
module led_bank_control_bench;
	// short duty window keeps each measurement brief
	localparam int WIN = 256;
	// host wait after enable, 20 us at 100 ns
	localparam int START_WAIT = 200;
	logic aclk, aresetn;
	logic [7:0] awaddr, araddr, hi_cyc, lo_cyc;
	logic [31:0] wdata, rdata;
	logic [3:0] wstrb;
	logic awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready;
	logic [1:0] bresp, rresp;
	logic en_pin, pwm, hot, cool, boost_en, boost_clk;
	logic [2:0] sink_en;
	logic [2:0][4:0] fs;
	logic [2:0][10:0] lvl;
	int n_errors = 0;
	int check_count = 0;
	int cycles = 0;
	lbc_top #(.WINDOW_CYC(WIN)) dut (
		.aclk(aclk),
		.aresetn(aresetn),
		.s_axi_awaddr(awaddr),
		.s_axi_awprot(3'h0),
		.s_axi_awvalid(awvalid),
		.s_axi_awready(awready),
		.s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid),
		.s_axi_wready(wready),
		.s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid),
		.s_axi_bready(bready),
		.s_axi_araddr(araddr),
		.s_axi_arprot(3'h0),
		.s_axi_arvalid(arvalid),
		.s_axi_arready(arready),
		.s_axi_rdata(rdata),
		.s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid),
		.s_axi_rready(rready),
		.global_enable_pin(en_pin),
		.pwm_pin(pwm),
		.temp_hot_pin(hot),
		.temp_cool_pin(cool),
		.boost_enable(boost_en),
		.boost_clk(boost_clk),
		.sink_enable(sink_en),
		.sink_fullscale(fs),
		.sink_level(lvl)
	);
	// far side pwm source
	lbc_pwm_source src (
		.aclk(aclk),
		.high_cyc(hi_cyc),
		.low_cyc(lo_cyc),
		.pwm_pin(pwm)
	);
	//////////////////////////////////////////////////////////////////////
	// clock, 100 ns period
	initial begin
		aclk = 1'b0;
		forever #50 aclk = ~aclk;
	end
	// hang guard, far above the expected run length
	always @(posedge aclk) begin
		cycles++;
		if (cycles == 20000) begin
			n_errors++;
			give_verdict();
		end
	end
	//////////////////////////////////////////////////////////////////////
	// compare and count
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	// closing report
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : give_verdict
	// axi write; readies looked at on the falling edge, where settled
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic aw_ok, w_ok, aw_hit, w_hit;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		aw_ok = 1'b0;
		w_ok = 1'b0;
		while (!(aw_ok && w_ok)) begin
			@(negedge aclk);
			aw_hit = awready && !aw_ok;
			w_hit = wready && !w_ok;
			@(posedge aclk);
			if (aw_hit) begin
				awvalid <= 1'b0;
			end
			if (w_hit) begin
				wvalid <= 1'b0;
			end
			aw_ok = aw_ok || aw_hit;
			w_ok = w_ok || w_hit;
		end
		// bready stays up until bvalid is seen
		do @(negedge aclk); while (bvalid !== 1'b1);
		@(posedge aclk);
		bready <= 1'b0;
	endtask : wr
	// axi read returning data and response
	task automatic rd(input logic [7:0] a, output logic [31:0] d,
			output logic [1:0] r);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(negedge aclk); while (arready !== 1'b1);
		@(posedge aclk);
		arvalid <= 1'b0;
		do @(negedge aclk); while (rvalid !== 1'b1);
		d = rdata;
		r = rresp;
		@(posedge aclk);
		rready <= 1'b0;
	endtask : rd
	//////////////////////////////////////////////////////////////////////
	// reset values and an unmapped read
	task automatic t_defaults();
		logic [31:0] d;
		logic [1:0] r;
		rd(`LBC_OFF_FS_A, d, r);
		check(d, 32'h0000_0013);
		rd(`LBC_OFF_BR_B, d, r);
		check(d, 32'h0000_0000);
		rd(8'h20, d, r);
		check({r, d[29:0]}, {`LBC_RESP_SLVERR, 30'h0000_0000});
		$display("test defaults done");
	endtask : t_defaults
	// enable low shuts down, drops writes and clears registers
	task automatic t_shutdown();
		logic [31:0] d;
		logic [1:0] r;
		wr(`LBC_OFF_BR_A, 32'h0000_0155);
		rd(`LBC_OFF_BR_A, d, r);
		check(d, 32'h0000_0155);
		en_pin <= 1'b0;
		repeat (12) @(negedge aclk);
		check({28'h0, boost_en, sink_en}, 32'h0000_0000);
		wr(`LBC_OFF_BR_A, 32'h0000_02AA);
		@(posedge aclk);
		en_pin <= 1'b1;
		repeat (START_WAIT) @(posedge aclk);
		rd(`LBC_OFF_BR_A, d, r);
		check(d, 32'h0000_0000);
		$display("test shutdown done");
	endtask : t_shutdown
	// field widths and string to bank mapping, pwm off
	task automatic t_map();
		logic [31:0] d;
		logic [1:0] r;
		wr(`LBC_OFF_FS_A, 32'hFFFF_FFFF);
		rd(`LBC_OFF_FS_A, d, r);
		check(d, 32'h0000_001F);
		wr(`LBC_OFF_BR_A, 32'hFFFF_FFFF);
		rd(`LBC_OFF_BR_A, d, r);
		check(d, 32'h0000_07FF);
		wr(`LBC_OFF_FS_B, 32'h0000_0005);
		wr(`LBC_OFF_BR_B, 32'h0000_0023);
		// lane 1 only: low byte must keep 0x23
		wstrb <= 4'h2;
		wr(`LBC_OFF_BR_B, 32'h0000_01FF);
		wstrb <= 4'hF;
		// strings 1 and 3 on bank b, string 2 on bank a
		wr(`LBC_OFF_SINK, 32'h0000_0005);
		repeat (3) @(negedge aclk);
		check({17'h0, fs}, {17'h0, 5'h05, 5'h1F, 5'h05});
		check({10'h0, lvl[2:1]}, {10'h0, 11'h123, 11'h7FF});
		check({21'h0, lvl[0]}, 32'h0000_0123);
		check({29'h0, sink_en}, 32'h0000_0007);
		$display("test map done");
	endtask : t_map
	// one pwm setting: string 2 (bank a) in a range, string 1 exact
	task automatic pwm_case(input logic [3:0] cfg, input logic [7:0] h,
			input logic [7:0] l, input logic [10:0] lo_b,
			input logic [10:0] hi_b, input logic [10:0] b_lvl);
		hi_cyc <= h;
		lo_cyc <= l;
		wr(`LBC_OFF_PWM, {28'h0, cfg});
		// three windows: one partial, one full, one to publish
		repeat (3 * WIN) @(negedge aclk);
		check({31'h0, lvl[1] >= lo_b && lvl[1] <= hi_b}, 32'h1);
		check({21'h0, lvl[0]}, {21'h0, b_lvl});
	endtask : pwm_case
	task automatic t_pwm();
		pwm_case(4'h1, 8'h10, 8'h00, 11'h7FF, 11'h7FF, 11'h123);
		pwm_case(4'h1, 8'h00, 8'h10, 11'h000, 11'h000, 11'h123);
		pwm_case(4'h2, 8'h00, 8'h10, 11'h7FF, 11'h7FF, 11'h000);
		pwm_case(4'h5, 8'h00, 8'h10, 11'h7FF, 11'h7FF, 11'h123);
		pwm_case(4'h1, 8'h04, 8'h0C, 11'h000, 11'h000, 11'h123);
		pwm_case(4'h9, 8'h04, 8'h0C, 11'h1C0, 11'h23F, 11'h123);
		pwm_case(4'h1, 8'h10, 8'h10, 11'h3C0, 11'h43F, 11'h123);
		$display("test pwm done");
	endtask : t_pwm
	// boost clock high time: 10 cycles slow, 5 fast
	task automatic t_boost();
		int n;
		for (int f = 0; f < 2; f++) begin
			wr(`LBC_OFF_BOOST, f[31:0]);
			// skip one period so the new rate is settled
			@(posedge boost_clk);
			@(posedge boost_clk);
			n = 0;
			@(negedge aclk);
			while (boost_clk === 1'b1 && n < 40) begin
				n++;
				@(negedge aclk);
			end
			check(n, (f == 0) ? 32'd10 : 32'd5);
		end
		$display("test boost done");
	endtask : t_boost
	// thermal trip holds until the cool level is reported
	task automatic t_thermal();
		logic [31:0] d;
		logic [1:0] r;
		@(posedge aclk);
		hot <= 1'b1;
		repeat (10) @(negedge aclk);
		check({28'h0, boost_en, sink_en}, 32'h0000_0000);
		// status: enabled, latched hot, not active, half duty (128)
		rd(`LBC_OFF_STATUS, d, r);
		check({r, d[29:0]}, {`LBC_RESP_OKAY, 30'h0000_8003});
		@(posedge aclk);
		hot <= 1'b0;
		repeat (20) @(negedge aclk);
		check({28'h0, boost_en, sink_en}, 32'h0000_0000);
		@(posedge aclk);
		cool <= 1'b1;
		repeat (10) @(negedge aclk);
		check({28'h0, boost_en, sink_en}, 32'h0000_000F);
		@(posedge aclk);
		cool <= 1'b0;
		$display("test thermal done");
	endtask : t_thermal
	//////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		aresetn = 1'b0;
		en_pin = 1'b0;
		hot = 1'b0;
		cool = 1'b0;
		hi_cyc = 8'h00;
		lo_cyc = 8'h10;
		awaddr = 8'h00;
		araddr = 8'h00;
		wdata = 32'h0000_0000;
		wstrb = 4'hF;
		awvalid = 1'b0;
		wvalid = 1'b0;
		bready = 1'b0;
		arvalid = 1'b0;
		rready = 1'b0;
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		en_pin <= 1'b1;
		repeat (START_WAIT) @(posedge aclk);
		t_defaults();
		t_shutdown();
		t_map();
		t_pwm();
		t_boost();
		t_thermal();
		give_verdict();
	end
endmodule : led_bank_control_bench
